// File: hw/dbp_pkg.sv
package dbp_pkg;
   // ************************************************************
   // widths and counts
   // ************************************************************
   localparam int COEF_W = 8;
   localparam int CODE_W = 5;
   localparam int WORD_W = 32;
   localparam int CTRL_W = 16;
   localparam int ADDR_W = 13;
   localparam int ARRAY_AW = 10;
   localparam int CS_W = 3;
   localparam int LOOP_STEPS = 16;
   localparam int PACK_STEPS = 32;
   localparam int PCTL_W = 7;
   localparam int STROBE_DEPTH = 64;
   localparam int SHIFTERS = 8;
   localparam int SHIFTER_W = 4;
   // ************************************************************
   // start decodes and timing
   // ************************************************************
   localparam logic [2:0] WR_START_DECODE = 3'h6;
   localparam logic [3:0] PACK_START_DECODE = 4'h3;
   localparam logic [4:0] BLOCKS_512 = 5'h10;
   localparam logic [4:0] BLOCKS_256 = 5'h08;
   localparam logic [4:0] BLOCKS_128 = 5'h04;
   localparam logic [9:0] LINE_PIXELS = 10'h264;
   localparam logic [9:0] ACTIVE_START = 10'h064;
   localparam logic [4:0] BITS_PER_WORD = 5'h1f;
   // ************************************************************
   // packer control entry fields
   // ************************************************************
   localparam int PC_KEEP_LSB = 0;
   localparam int PC_ALIGN_LSB = 3;
   localparam int PC_SWAP_BIT = 5;
   localparam int PC_STORE_BIT = 6;
   // ************************************************************
   // test mode, reset address, clamp limits, resolutions
   // ************************************************************
   localparam logic [7:0] TEST_STROBE_DIV = 8'h3f;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 13'h0000;
   localparam logic [7:0] LIMIT_MAX = 8'h7f;
   localparam logic [7:0] LIMIT_MIN = 8'h80;
   typedef enum logic [1:0] {RES_512, RES_256, RES_128} dbp_res_t;
endpackage : dbp_pkg

// File: hw/dbp_top.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - block start pulse 16, 8 or 4 times per line by resolution
// - first active line differenced against zero while gate is active
// - read counter walks 16 addresses per start, then halts
// - low four read bits pick coefficient; line memory gives matching value
// - 8-bit difference maps to 5-bit code through first table
// - code goes to packer and second table regenerating 8-bit value
// - regenerated value plus stored value, clamped on overflow
// - scaled result written back at the address read
// - two loops of 16 interleaved into packer at double rate
// - write counter starts at read low bits six, steps 16, halts
// - packer keeps 0 to 5 bits per code into 32-bit words
// - control entry: keep count, align, swap, store flag
// - six control bits address 64x8 strobe table for 8 shifters
// - packer counter starts at read count three, steps 32, halts
// - packer control memory loaded during first field blanking
// - frame marker starts store; field one bank one, field two bank two
// - read of bank one starts once full, through serializer and shifter
// - sync loads control word ahead of data, leaves with its last bit
// - test mode makes own marker and strobe; stores data lines
// - strobe latches word; bank write drives latch onto memory bus
// - 13-bit address, low 10 to array, top 3 to eight selects
// - write inactive means read; load moves word into serializer
// - new word enters serializer every 32 modem clocks
// - after bank two, serial output forced to zero until next frame
module dbp_top #(
   parameter int BANK_WORDS = 4096
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic modem_clk,
   input wire dbp_pkg::dbp_res_t resolution,
   input wire logic [9:0] pixel_count,
   input wire logic zero_first_line_gate,
   input wire logic field_one_blank,
   input wire logic pctl_load_en,
   input wire logic [4:0] pctl_load_addr,
   input wire logic [6:0] pctl_load_data,
   input wire logic [7:0] coef_a,
   input wire logic [7:0] coef_b,
   input wire logic frame_zero_marker,
   input wire logic test_mode,
   input wire logic [31:0] test_word,
   input wire logic [15:0] control_word,
   output logic [3:0] coef_sel,
   output logic pack_word_strobe,
   output logic [31:0] pack_word,
   output logic [12:0] mem_addr,
   output logic [7:0] mem_cs,
   output logic bank_one_write,
   output logic bank_two_write,
   output logic serial_data,
   output logic serial_sync
);
   import dbp_pkg::*;

   // store depth per bank must be a power of two
   localparam int BANK_AW = $clog2(BANK_WORDS);

   // frame store index: bank select above the word address in that bank
   function automatic logic [BANK_AW:0] bank_index(
      input logic bank,
      input logic [ADDR_W-1:0] addr
   );
      return {bank, addr[BANK_AW-1:0]};
   endfunction : bank_index

   // ************************************************************
   // block start decode
   // ************************************************************
   logic block_start_pulse;
   logic [9:0] rel_pix;
   logic [4:0] pitch_mask;
   always_comb begin
      rel_pix = pixel_count - ACTIVE_START;
      case (resolution)
         RES_256: pitch_mask = BLOCKS_256;
         RES_128: pitch_mask = BLOCKS_128;
         default: pitch_mask = BLOCKS_512;
      endcase
   end
   // 512/blocks pixels apart: 32, 64 or 128
   always_comb begin
      block_start_pulse = 1'b0;
      if (pixel_count >= ACTIVE_START && pixel_count < LINE_PIXELS) begin
         case (pitch_mask)
            BLOCKS_256: block_start_pulse = rel_pix[5:0] == 6'h00;
            BLOCKS_128: block_start_pulse = rel_pix[6:0] == 7'h00;
            default: block_start_pulse = rel_pix[4:0] == 5'h00;
         endcase
      end
   end

   // ************************************************************
   // address counters
   // ************************************************************
   logic [3:0] rd_q, wr_q;
   logic rd_run_q, wr_run_q, pk_run_q;
   logic [4:0] pk_q;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_q <= 4'h0;
         rd_run_q <= 1'b0;
      end else if (block_start_pulse && !rd_run_q) begin
         rd_run_q <= 1'b1;
         rd_q <= 4'h0;
      end else if (rd_run_q) begin
         rd_q <= rd_q + 4'h1;
         if (rd_q == 4'hf) rd_run_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= 4'h0;
         wr_run_q <= 1'b0;
      end else if (rd_run_q && rd_q[2:0] == WR_START_DECODE && !wr_run_q) begin
         wr_run_q <= 1'b1;
         wr_q <= 4'h0;
      end else if (wr_run_q) begin
         wr_q <= wr_q + 4'h1;
         if (wr_q == 4'hf) wr_run_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pk_q <= 5'h00;
         pk_run_q <= 1'b0;
      end else if (rd_run_q && rd_q == PACK_START_DECODE
            && (!pk_run_q || pk_q == 5'h1f)) begin
         // in 512 mode the next start meets the last step: restart at once
         pk_run_q <= 1'b1;
         pk_q <= 5'h00;
      end else if (pk_run_q) begin
         pk_q <= pk_q + 5'h01;
         if (pk_q == 5'h1f) pk_run_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) coef_sel <= 4'h0;
      else coef_sel <= rd_q;
   end

   // ************************************************************
   // dpcm loops, one generate copy per coefficient group
   // ************************************************************
   logic [4:0] code_q [2];
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_loop
         logic [7:0] line_mem [LOOP_STEPS];
         logic [7:0] prev_q, diff_q, regen_q, sum_q;
         logic [3:0] a1_q, a2_q, a3_q, a4_q;
         logic [8:0] raw_sum;
         logic [7:0] present;
         assign present = (g == 0) ? coef_a : coef_b;
         assign raw_sum = {regen_q[7], regen_q} + {prev_q[7], prev_q};
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               prev_q <= 8'h00;
               diff_q <= 8'h00;
               code_q[g] <= 5'h00;
               regen_q <= 8'h00;
               sum_q <= 8'h00;
            end else begin
               // zero reference on the first line of a field
               prev_q <= zero_first_line_gate ? 8'h00 : line_mem[rd_q];
               diff_q <= present - prev_q;
               code_q[g] <= diff_q[7:3];
               regen_q <= {code_q[g], 3'h0};
               if (raw_sum[8] != raw_sum[7])
                  sum_q <= raw_sum[8] ? LIMIT_MIN : LIMIT_MAX;
               else
                  sum_q <= raw_sum[7:0];
            end
         end
         always_ff @(posedge ref_clk) begin
            // scaled by unity step in second adder
            if (wr_run_q) line_mem[wr_q] <= sum_q + 8'h00;
         end
      end
   endgenerate

   // ************************************************************
   // bit packer
   // ************************************************************
   logic [6:0] pctl_mem [PACK_STEPS];
   logic [6:0] pctl;
   logic [7:0] strobe_rom [STROBE_DEPTH];
   logic [4:0] in_code;
   logic [31:0] acc_q;
   logic [5:0] fill_q;
   always_ff @(posedge ref_clk) begin
      if (pctl_load_en && field_one_blank)
         pctl_mem[pctl_load_addr] <= pctl_load_data;
   end
   assign pctl = pctl_mem[pk_q];
   assign in_code = code_q[pk_q[0]];
   always_comb begin
      for (int i = 0; i < STROBE_DEPTH; i++)
         strobe_rom[i] = 8'hff >> (3'(i) ^ 3'h7);
   end
   logic [4:0] kept;
   logic [2:0] kn;
   always_comb begin
      kn = (pctl[2:0] > 3'h5) ? 3'h5 : pctl[2:0];
      kept = in_code >> (3'h5 - kn);
      if (pctl[PC_SWAP_BIT] && strobe_rom[pctl[5:0]] == 8'h00) kept = 5'h00;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         acc_q <= 32'h0000_0000;
         fill_q <= 6'h00;
         pack_word <= 32'h0000_0000;
         pack_word_strobe <= 1'b0;
      end else begin
         pack_word_strobe <= 1'b0;
         if (test_mode) begin
            pack_word_strobe <= &pixel_count[5:0];
            // the word changes only with its strobe
            if (&pixel_count[5:0]) pack_word <= test_word;
         end else if (pk_run_q) begin
            acc_q <= (acc_q << kn) | {27'h0, kept};
            if (pctl[PC_STORE_BIT]) begin
               pack_word <= (acc_q << kn) | {27'h0, kept};
               pack_word_strobe <= 1'b1;
               fill_q <= 6'h00;
            end else fill_q <= fill_q + {3'h0, kn};
         end
      end
   end

   // ************************************************************
   // frame store write side
   // ************************************************************
   logic [31:0] bank_mem [2*BANK_WORDS];
   logic [31:0] latch_q;
   logic [12:0] wa_q;
   logic wbank_q, store_q, bank1_full_t_q;
   logic fz_q;
   logic fz_edge;
   logic test_fz;
   logic fz_src;
   assign test_fz = test_mode && pixel_count == 10'h000;
   // test mode ignores the outside marker
   assign fz_src = test_mode ? test_fz : frame_zero_marker;
   assign fz_edge = fz_src && !fz_q;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         fz_q <= 1'b0;
         wa_q <= RESET_ADDR;
         wbank_q <= 1'b0;
         store_q <= 1'b0;
         latch_q <= 32'h0000_0000;
         bank1_full_t_q <= 1'b0;
         bank_one_write <= 1'b0;
         bank_two_write <= 1'b0;
      end else begin
         fz_q <= fz_src;
         bank_one_write <= 1'b0;
         bank_two_write <= 1'b0;
         if (fz_edge) begin
            store_q <= 1'b1;
            wa_q <= RESET_ADDR;
            wbank_q <= 1'b0;
         end else if (pack_word_strobe) begin
            latch_q <= pack_word;
            if (store_q) begin
               bank_one_write <= !wbank_q;
               bank_two_write <= wbank_q;
               if (wa_q == 13'(BANK_WORDS - 1)) begin
                  wa_q <= RESET_ADDR;
                  wbank_q <= 1'b1;
                  if (!wbank_q) bank1_full_t_q <= !bank1_full_t_q;
                  else store_q <= 1'b0;
               end else wa_q <= wa_q + 13'h0001;
            end
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (bank_one_write || bank_two_write)
         bank_mem[bank_index(bank_two_write, mem_addr)] <= latch_q;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mem_addr <= RESET_ADDR;
         mem_cs <= 8'h00;
      end else begin
         mem_addr <= wa_q;
         mem_cs <= 8'h01 << wa_q[ADDR_W-1:ARRAY_AW];
      end
   end

   // ************************************************************
   // modem clock domain readout
   // ************************************************************
   logic [2:0] full_sync_q;
   logic [12:0] ra_q;
   logic rbank_q, reading_q, zero_fill_q;
   logic [4:0] bit_q;
   logic [31:0] parallel_to_serial_shifter_q;
   logic [15:0] ctl_sr_q, sync_sr_q;
   logic first_q;
   logic [12:0] ra_nxt;
   assign ra_nxt = ra_q + 13'h0001;
   // bank one is read only once it is full; bank two is read straight after it, with no check that it is full
   // the full toggle crosses to the modem clock through two flops
   always_ff @(posedge modem_clk or negedge resetn) begin
      if (!resetn) full_sync_q <= 3'h0;
      else full_sync_q <= {full_sync_q[1:0], bank1_full_t_q};
   end
   always_ff @(posedge modem_clk or negedge resetn) begin
      if (!resetn) begin
         ra_q <= RESET_ADDR;
         rbank_q <= 1'b0;
         reading_q <= 1'b0;
         zero_fill_q <= 1'b1;
         bit_q <= 5'h00;
         parallel_to_serial_shifter_q <= 32'h0000_0000;
         first_q <= 1'b0;
      end else begin
         first_q <= 1'b0;
         if (full_sync_q[2] != full_sync_q[1]) begin
            reading_q <= 1'b1;
            zero_fill_q <= 1'b0;
            ra_q <= RESET_ADDR;
            rbank_q <= 1'b0;
            bit_q <= 5'h00;
            parallel_to_serial_shifter_q <= bank_mem[bank_index(1'b0, RESET_ADDR)];
            first_q <= 1'b1;
         end else if (reading_q && !first_q) begin
            // held one clock while the control word loads, so no bit is lost
            bit_q <= bit_q + 5'h01;
            parallel_to_serial_shifter_q <= {parallel_to_serial_shifter_q[30:0], 1'b0};
            if (bit_q == BITS_PER_WORD) begin
               if (ra_q == 13'(BANK_WORDS - 1)) begin
                  ra_q <= RESET_ADDR;
                  rbank_q <= 1'b1;
                  if (rbank_q) begin
                     reading_q <= 1'b0;
                     zero_fill_q <= 1'b1;
                  end
                  parallel_to_serial_shifter_q <= bank_mem[bank_index(1'b1, RESET_ADDR)];
               end else begin
                  ra_q <= ra_nxt;
                  parallel_to_serial_shifter_q <= bank_mem[bank_index(rbank_q, ra_nxt)];
               end
            end
         end
      end
   end
   always_ff @(posedge modem_clk or negedge resetn) begin
      if (!resetn) begin
         ctl_sr_q <= 16'h0000;
         sync_sr_q <= 16'h0000;
         // control word goes out ahead of the first data bit
         serial_data <= 1'b0;
         serial_sync <= 1'b0;
      end else begin
         if (first_q) begin
            ctl_sr_q <= control_word;
            sync_sr_q <= 16'h0001;
         end else begin
            ctl_sr_q <= {ctl_sr_q[14:0], zero_fill_q ? 1'b0 : parallel_to_serial_shifter_q[31]};
            sync_sr_q <= {sync_sr_q[14:0], 1'b0};
         end
         serial_data <= ctl_sr_q[15] & !(zero_fill_q && !reading_q && ctl_sr_q == 16'h0);
         serial_sync <= sync_sr_q[15];
      end
   end
endmodule : dbp_top
`default_nettype wire

// File: tb/dbp_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dbp_top_assertions (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic modem_clk,
   input wire logic [3:0] coef_sel,
   input wire logic pack_word_strobe,
   input wire logic [31:0] pack_word,
   input wire logic [12:0] mem_addr,
   input wire logic [7:0] mem_cs,
   input wire logic bank_one_write,
   input wire logic bank_two_write,
   input wire logic serial_sync
);
   logic [3:0] sel_prev_q;
   logic [4:0] run_q;
   // length of the current unbroken run of selector steps
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sel_prev_q <= 4'h0;
         run_q <= 5'h00;
      end else begin
         sel_prev_q <= coef_sel;
         run_q <= (coef_sel != sel_prev_q) ? run_q + 5'h01 : 5'h00;
      end
   end
   sequence s_sync_rise;
      !serial_sync ##1 serial_sync;
   endsequence
   a_sel_steps_one: assert property (@(posedge ref_clk) disable iff (!resetn)
      coef_sel != $past(coef_sel) |-> coef_sel == $past(coef_sel) + 4'h1)
      else $error("selector skipped an address");
   a_sel_run_len: assert property (@(posedge ref_clk) disable iff (!resetn)
      run_q <= 5'h10) else $error("read counter ran past 16 steps");
   a_strobe_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      pack_word_strobe |=> !pack_word_strobe) else $error("strobe too long");
   a_word_stands: assert property (@(posedge ref_clk) disable iff (!resetn)
      !pack_word_strobe |-> $stable(pack_word)) else $error("word moved");
   a_cs_decode: assert property (@(posedge ref_clk) disable iff (!resetn)
      (bank_one_write || bank_two_write) |->
      mem_cs == (8'h01 << mem_addr[12:10])) else $error("bad chip select");
   a_banks_apart: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(bank_one_write && bank_two_write)) else $error("both banks written");
   a_write_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      (bank_one_write || bank_two_write) |=>
      !(bank_one_write || bank_two_write)) else $error("write too long");
   a_sync_pulse: assert property (@(posedge modem_clk) disable iff (!resetn)
      s_sync_rise |=> !serial_sync) else $error("sync too long");
   a_reset_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> mem_addr == 13'h0000 && coef_sel == 4'h0
      && !pack_word_strobe) else $error("not clear after reset");
endmodule : dbp_top_assertions
bind dbp_top dbp_top_assertions u_chk (.ref_clk(ref_clk), .resetn(resetn),
   .modem_clk(modem_clk), .coef_sel(coef_sel),
   .pack_word_strobe(pack_word_strobe), .pack_word(pack_word),
   .mem_addr(mem_addr), .mem_cs(mem_cs), .bank_one_write(bank_one_write),
   .bank_two_write(bank_two_write), .serial_sync(serial_sync));
`default_nettype wire

// File: tb/dbp_modem_model.sv
`timescale 1ns/100ps
`default_nettype none
// receiver: frames words from the serial stream after each sync
module dbp_modem_model (
   input wire logic modem_clk,
   input wire logic resetn,
   input wire logic serial_data,
   input wire logic serial_sync,
   output logic [15:0] ctrl_q,
   output logic [31:0] word_q,
   output logic [7:0] words_q,
   output logic [7:0] ones_q,
   output logic [7:0] syncs_q
);
   logic [31:0] sh_q;
   logic [4:0] bit_q;
   always_ff @(posedge modem_clk or negedge resetn) begin
      if (!resetn) begin
         sh_q <= 32'h0000_0000;
         bit_q <= 5'h00;
         ctrl_q <= 16'h0000;
         word_q <= 32'h0000_0000;
         words_q <= 8'h00;
         ones_q <= 8'h00;
         syncs_q <= 8'h00;
      end else begin
         sh_q <= {sh_q[30:0], serial_data};
         bit_q <= bit_q + 5'h01;
         if (words_q >= 8'h10 && serial_data)
            ones_q <= ones_q + 8'h01;
         if (serial_sync) begin
            ctrl_q <= {sh_q[14:0], serial_data};
            syncs_q <= syncs_q + 8'h01;
            bit_q <= 5'h00;
            words_q <= 8'h00;
            ones_q <= 8'h00;
         end else if (bit_q == 5'h1f) begin
            word_q <= {sh_q[30:0], serial_data};
            words_q <= words_q + 8'h01;
         end
      end
   end
endmodule : dbp_modem_model
`default_nettype wire

// File: tb/test_dpcm_bit_packer_frame_store.sv
`timescale 1ns/100ps
`default_nettype none
module test_dpcm_bit_packer_frame_store;
   import dbp_pkg::*;
   typedef struct {dbp_res_t r; logic g; logic [7:0] c;
      logic [31:0] w; int n;} dbp_row_t;
   logic ref_clk = 1'b0, modem_clk = 1'b0, resetn = 1'b0;
   dbp_res_t res = RES_512;
   logic [9:0] pix = 10'h000;
   logic gate = 1'b1, blank = 1'b0, ld_en = 1'b0, mark = 1'b0;
   logic [4:0] ld_addr = 5'h00;
   logic [6:0] ld_data = 7'h00;
   logic [7:0] coef = 8'h00;
   logic tmode = 1'b0;
   logic [31:0] tword = 32'h3c5a_96e1;
   logic [3:0] sel;
   logic strobe, b1, b2, sdata, ssync;
   logic [31:0] word, m_word;
   logic [12:0] addr;
   logic [7:0] cs, m_words, m_ones, m_syncs;
   logic [15:0] m_ctrl;
   int err_count = 0, compares = 0, n_str = 0, n_b1 = 0, n_b2 = 0;
   localparam logic [15:0] CTRL = 16'ha5c3;
   dbp_row_t rows [5] = '{
      '{RES_512, 1'b1, 8'hf8, 32'hffff_ffff, 64},
      '{RES_256, 1'b1, 8'hf8, 32'hffff_ffff, 32},
      '{RES_128, 1'b1, 8'h00, 32'h0000_0000, 16},
      '{RES_512, 1'b1, 8'hf8, 32'hffff_ffff, 64},
      '{RES_512, 1'b0, 8'hf8, 32'h0000_0000, 64}};
   always #4 ref_clk = ~ref_clk;
   initial begin
      #3.3;
      forever #40 modem_clk = ~modem_clk;
   end
   always @(negedge ref_clk) pix <= (pix == 10'h263) ? 10'h000 : pix + 10'h001;
   dbp_top #(.BANK_WORDS(8)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .modem_clk(modem_clk), .resolution(res), .pixel_count(pix),
      .zero_first_line_gate(gate), .field_one_blank(blank),
      .pctl_load_en(ld_en), .pctl_load_addr(ld_addr),
      .pctl_load_data(ld_data), .coef_a(coef), .coef_b(coef),
      .frame_zero_marker(mark), .test_mode(tmode), .test_word(tword),
      .control_word(CTRL), .coef_sel(sel), .pack_word_strobe(strobe),
      .pack_word(word), .mem_addr(addr), .mem_cs(cs), .bank_one_write(b1),
      .bank_two_write(b2), .serial_data(sdata), .serial_sync(ssync));
   dbp_modem_model u_modem (.modem_clk(modem_clk), .resetn(resetn),
      .serial_data(sdata), .serial_sync(ssync), .ctrl_q(m_ctrl),
      .word_q(m_word), .words_q(m_words), .ones_q(m_ones),
      .syncs_q(m_syncs));
   // ************************************************************
   // checking and stepping
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic run(input int n, input logic chk, input logic [31:0] exp);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (strobe === 1'b1) begin
            n_str++;
            if (chk) check("pack word", word, exp);
         end
         if (b1 === 1'b1) begin
            check("bank one address", addr, n_b1);
            n_b1++;
         end
         if (b2 === 1'b1) begin
            check("bank two address", addr, n_b2);
            n_b2++;
         end
      end
   endtask : run
   task automatic wait_modem(input logic [7:0] w);
      for (int i = 0; i < 9000 && m_words < w; i++) run(1, 1'b0, 32'h0);
      if (m_words < w) begin
         err_count++;
         give_verdict();
      end
   endtask : wait_modem
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (2) @(posedge modem_clk);
      @(negedge ref_clk) resetn = 1'b1;
      blank = 1'b1;
      ld_en = 1'b1;
      for (int k = 0; k < 32; k++) begin
         ld_addr = k[4:0];
         ld_data = {k[2:0] == 3'h7, 3'h0, 3'h4};
         @(negedge ref_clk);
      end
      // this late write must be ignored, keeping the store flag of entry 7
      blank = 1'b0;
      ld_addr = 5'h07;
      ld_data = 7'h04;
      @(negedge ref_clk) ld_en = 1'b0;
      foreach (rows[i]) begin
         @(negedge ref_clk);
         res = rows[i].r;
         gate = rows[i].g;
         coef = rows[i].c;
         for (int j = 0; j < 612 && pix !== 10'h032; j++)
            run(1, 1'b0, 32'h0);
         run(612, 1'b0, 32'h0);
         n_str = 0;
         run(612, 1'b1, rows[i].w);
         check("strobes per line", n_str, rows[i].n);
      end
      check("writes without marker", n_b1 + n_b2, 0);
      @(negedge ref_clk) gate = 1'b1;
      run(612, 1'b0, 32'h0);
      @(negedge ref_clk) mark = 1'b1;
      run(1224, 1'b1, 32'hffff_ffff);
      @(negedge ref_clk) mark = 1'b0;
      check("bank one words", n_b1, 8);
      check("bank two words", n_b2, 8);
      wait_modem(8'h10);
      check("sync count", m_syncs, 1);
      check("control word", m_ctrl, CTRL);
      check("last data word", m_word, 32'hffff_ffff);
      wait_modem(8'h11);
      check("fill word", m_word, 32'h0000_0000);
      check("fill ones", m_ones, 0);
      // test mode: own strobe every 64 pixels, own marker at pixel 0
      @(negedge ref_clk) tmode = 1'b1;
      @(negedge ref_clk);
      n_str = 0;
      n_b1 = 0;
      n_b2 = 0;
      run(612, 1'b1, tword);
      check("test strobes per line", n_str, 9);
      @(negedge ref_clk) resetn = 1'b0;
      tmode = 1'b0;
      #1;
      check("outputs in reset", {strobe, b1, b2, sdata, ssync, addr, sel},
         0);
      repeat (2) @(posedge modem_clk);
      @(negedge ref_clk) resetn = 1'b1;
      run(50, 1'b0, 32'h0);
      give_verdict();
   end
endmodule : test_dpcm_bit_packer_frame_store
`default_nettype wire
